//--- core/gfm_cfg.svh
// gfm_cfg.svh: offsets, field positions, reset values and timing counts of the gpio block
// assumes a 25 MHz system clock and an 8-bit byte address on the register bus
`ifndef GFM_CFG_SVH
`define GFM_CFG_SVH

// register byte offsets, per port block
`define GFM_PORT_STRIDE 8'h20
`define GFM_OFF_CFG 5'h00
`define GFM_OFF_OUT 5'h04
`define GFM_OFF_SET 5'h08
`define GFM_OFF_CLR 5'h0c
`define GFM_OFF_IN 5'h10
// debug block sits where a fourth port would be
`define GFM_DBG_PORT 2'h3
`define GFM_OFF_DBGCFG 5'h00
`define GFM_OFF_DBGSTAT 5'h04

// debug_config_reg fields
`define GFM_DBGCFG_EXTREG 0
`define GFM_DBGCFG_DISABLE 1
`define GFM_DBGCFG_RESET 2'h1
// debug_status_reg fields
`define GFM_STAT_FORCED 0
`define GFM_STAT_SWMODE 1
`define GFM_STAT_BOOTSEL 2
`define GFM_STAT_MONITOR 3

// reset values
`define GFM_CFG_RESET 32'h44444444
`define GFM_OUT_RESET 8'h00

// forced pin positions in the flat 24-pin vector
`define GFM_PIN_BOOT 5
`define GFM_PIN_REG 7
`define GFM_PIN_TRST 16
`define GFM_PIN_TDO 18
`define GFM_PIN_TDI 19
`define GFM_PIN_TMS 20

// timing
`define GFM_CLK_MHZ 25
`define GFM_BOOT_OSC_CLKS 10'h200
`define GFM_MON_DELAY_US 3000

// bus responses
`define GFM_RESP_OKAY 2'h0
`define GFM_RESP_SLVERR 2'h2

`endif

//--- core/gfm_pkg.sv
// gfm_pkg: types shared by the gpio block
// constants live in gfm_cfg.svh
package gfm_pkg;

	typedef enum logic [3:0] {
		GFM_ANALOG = 4'h0,
		GFM_OUT_PP = 4'h1,
		GFM_IN_FLOAT = 4'h4,
		GFM_OUT_OD = 4'h5,
		GFM_IN_PULL = 4'h8,
		GFM_ALT_PP = 4'h9,
		GFM_ALT_OD = 4'hd
	} gfm_mode_t;

	typedef enum logic [1:0] {
		GFM_BT_RESET = 2'h0,
		GFM_BT_WAIT = 2'h1,
		GFM_BT_MON = 2'h2,
		GFM_BT_DONE = 2'h3
	} gfm_boot_st_t;

	// drive of one pad
	typedef struct packed {
		logic out;
		logic oe;
		logic pu;
		logic pd;
	} gfm_drv_t;

endpackage

//--- core/gfm_gpio.sv
// gfm_gpio: three 8-bit gpio ports with forced reset functions and boot-select sampling
// assumes pads, peripherals and debug port signals synchronous to mclk; registers on AXI4-Lite
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "gfm_cfg.svh"

// Functional notes
// - forced functions win after reset until software releases the regulator and debug pins; the boot pin is released after sampling
// - port_a_pin7 is an open-drain regulator_enable_out after reset
// - port_c pins 0,3 pull-up debug inputs, pin 2 push-pull debug_tdo
// - port_c_pin4 is pull-up tms in jtag, debugger-driven swdio in serial wire
// - clearing ext_regulator_enable_bit returns port_a_pin7 to plain gpio
// - debug port starts in jtag; only the debug tool picks the mode
// - debug_port_disable set makes the four debug pins plain gpio
// - setting debug_port_disable is ignored while the debug port is powered up
// - debug power-up during reset reclaims the pins and sets debug_forced_flag
// - power-on, pin reset, watchdog and reset request are full-chip resets
// - full-chip reset puts every pin_mode_config into floating input
// - full-chip reset sets regulator enable and clears debug disable
// - boot select honoured only after pin reset or always-on power-on reset
// - boot pin pulled up through reset plus 512 oscillator clocks, then sampled
// - monitor re-samples after 3 ms and stays only if still low
// - after sampling the boot pin floats and boot_select_flag keeps the level
// - analog mode: no drivers, no pulls, input and readback read 1
// - pull input: latch 0 pulls down, 1 pulls up; floating has none
// - input mode: drivers off, pin to readback and to peripherals
// - output mode drives latch, open-drain or push-pull, pulls off
// - set and clear registers change only the bits written as one
// - reading output_latch returns the value written, not the pin
// - alternate output drives peripheral output with same encoding, pulls off
// - mode codes 0 analog, 4 float, 8 pull, 1/5 out, 9/d alternate
// - alternate output with no peripheral drives constant zero
module gfm_gpio #(
	parameter int ADDR_W = 8,
	parameter logic [23:0] ALT_PRESENT = 24'hffffff,
	parameter int MON_CYCLES = `GFM_MON_DELAY_US * `GFM_CLK_MHZ
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// full-chip reset sources, high while active
	input wire logic rst_por_lv,
	input wire logic rst_always_on_por,
	input wire logic rst_pin,
	input wire logic rst_wdog,
	input wire logic rst_sys_req,
	// one pulse per fast_rc_osc clock
	input wire logic osc_tick,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pads, port a bits 7:0, b 15:8, c 23:16
	input wire logic [23:0] pad_in,
	output logic [23:0] pad_out,
	output logic [23:0] pad_oe,
	output logic [23:0] pad_pu,
	output logic [23:0] pad_pd,
	// peripherals
	input wire logic [23:0] alt_out,
	output logic [23:0] periph_in,
	// regulator control, low asks the external regulator on
	input wire logic reg_en_level,
	// debug port
	input wire logic dbg_pwrup_req,
	input wire logic dbg_sw_mode,
	input wire logic debug_tdo,
	input wire logic swdio_out,
	input wire logic swdio_oe,
	output logic debug_trst_n,
	output logic debug_tdi,
	output logic debug_tms,
	output logic swdio_in,
	// boot
	output logic boot_monitor_sel
);

	localparam int MON_W = $clog2(MON_CYCLES + 1);

	// the decode reads address bit 7 for the out-of-range check
	if (ADDR_W < 8 || MON_CYCLES < 1) begin : g_bad_param
		$error("gfm_gpio: ADDR_W must be at least 8 and MON_CYCLES at least 1");
	end

	logic full_rst;
	logic [2:0][31:0] cfg_q;
	logic [2:0][7:0] latch_q;
	logic ext_reg_q;
	logic dbg_dis_q;
	logic forced_q;
	logic boot_flag_q;
	logic boot_armed_q;
	gfm_pkg::gfm_boot_st_t boot_st_q;
	logic [9:0] osc_cnt_q;
	logic [MON_W-1:0] mon_cnt_q;
	logic boot_window;
	logic reg_ovr;
	logic dbg_ovr;
	gfm_pkg::gfm_drv_t [23:0] drv_d;
	logic [23:0] din_d;
	logic [23:0] din_q;

	// bus state
	logic aw_free_q;
	logic w_free_q;
	logic [ADDR_W-1:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic do_write;
	logic [31:0] wmask;
	logic [1:0] wport;
	logic [4:0] wreg;
	logic wmapped;
	logic [31:0] rd_d;
	logic rd_ok;
	logic [1:0] rport;
	logic [4:0] rreg;

	assign full_rst = !resetn || rst_por_lv || rst_always_on_por || rst_pin || rst_wdog
		|| rst_sys_req;

	// write channel: address and data are taken in either order, then answered once
	assign do_write = !aw_free_q && !w_free_q && !bvalid_q;
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign wport = waddr_q[6:5];
	assign wreg = waddr_q[4:0];

	always_comb begin
		wmapped = 1'b0;
		if (waddr_q[ADDR_W-1:7] == '0) begin
			if (wport == `GFM_DBG_PORT)
				wmapped = (wreg == `GFM_OFF_DBGCFG);
			else
				wmapped = (wreg == `GFM_OFF_CFG) || (wreg == `GFM_OFF_OUT)
					|| (wreg == `GFM_OFF_SET) || (wreg == `GFM_OFF_CLR);
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			aw_free_q <= 1'b1;
			w_free_q <= 1'b1;
			waddr_q <= '0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `GFM_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && aw_free_q) begin
				aw_free_q <= 1'b0;
				waddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && w_free_q) begin
				w_free_q <= 1'b0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				bvalid_q <= 1'b1;
				bresp_q <= wmapped ? `GFM_RESP_OKAY : `GFM_RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				aw_free_q <= 1'b1;
				w_free_q <= 1'b1;
			end
		end
	end

	// port configuration and output latches
	always_ff @(posedge mclk) begin
		if (full_rst) begin
			cfg_q <= {3{`GFM_CFG_RESET}};
			latch_q <= {3{`GFM_OUT_RESET}};
		end else if (do_write && wmapped && wport != `GFM_DBG_PORT) begin
			unique case (wreg)
				`GFM_OFF_CFG: cfg_q[wport] <= (cfg_q[wport] & ~wmask) | (wdata_q & wmask);
				`GFM_OFF_OUT: if (wstrb_q[0]) latch_q[wport] <= wdata_q[7:0];
				// only ones change the latch, so no read-modify-write is needed
				`GFM_OFF_SET: if (wstrb_q[0]) latch_q[wport] <= latch_q[wport] | wdata_q[7:0];
				`GFM_OFF_CLR: if (wstrb_q[0]) latch_q[wport] <= latch_q[wport] & ~wdata_q[7:0];
				default: latch_q[wport] <= latch_q[wport];
			endcase
		end
	end

	// debug configuration
	always_ff @(posedge mclk) begin
		if (full_rst) begin
			{dbg_dis_q, ext_reg_q} <= `GFM_DBGCFG_RESET;
		end else begin
			if (do_write && wmapped && wport == `GFM_DBG_PORT && wstrb_q[0]) begin
				ext_reg_q <= wdata_q[`GFM_DBGCFG_EXTREG];
				// a powered-up debugger keeps its pins; clearing is always allowed
				if (!dbg_pwrup_req || !wdata_q[`GFM_DBGCFG_DISABLE])
					dbg_dis_q <= wdata_q[`GFM_DBGCFG_DISABLE];
			end
		end
	end

	// a debugger that powers up while the chip sits in reset takes the pins back
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			forced_q <= 1'b0;
		end else if (full_rst && dbg_pwrup_req) begin
			forced_q <= 1'b1;
		end
	end

	// boot select: arming survives the reset sources that do not honour the pin
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			boot_armed_q <= 1'b1;
		end else if (rst_pin || rst_always_on_por) begin
			boot_armed_q <= 1'b1;
		end else if (boot_st_q == gfm_pkg::GFM_BT_WAIT && !boot_armed_q) begin
			boot_armed_q <= 1'b0;
		end else if (boot_st_q == gfm_pkg::GFM_BT_MON || boot_st_q == gfm_pkg::GFM_BT_DONE) begin
			boot_armed_q <= 1'b0;
		end
	end

	// fast_rc_osc is not a clock here: osc_tick marks one of its edges, see the wait state
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			boot_st_q <= gfm_pkg::GFM_BT_RESET;
			osc_cnt_q <= 10'h000;
			mon_cnt_q <= '0;
			boot_flag_q <= 1'b1;
			boot_monitor_sel <= 1'b0;
		end else if (full_rst) begin
			boot_st_q <= gfm_pkg::GFM_BT_RESET;
			osc_cnt_q <= 10'h000;
			mon_cnt_q <= '0;
			boot_monitor_sel <= 1'b0;
		end else begin
			unique case (boot_st_q)
				gfm_pkg::GFM_BT_RESET: begin
					boot_st_q <= boot_armed_q ? gfm_pkg::GFM_BT_WAIT : gfm_pkg::GFM_BT_DONE;
				end
				gfm_pkg::GFM_BT_WAIT: begin
					if (osc_tick) begin
						osc_cnt_q <= osc_cnt_q + 10'h001;
						if (osc_cnt_q == `GFM_BOOT_OSC_CLKS - 10'h001) begin
							boot_flag_q <= pad_in[`GFM_PIN_BOOT];
							if (!pad_in[`GFM_PIN_BOOT]) begin
								boot_monitor_sel <= 1'b1;
								boot_st_q <= gfm_pkg::GFM_BT_MON;
							end else begin
								boot_st_q <= gfm_pkg::GFM_BT_DONE;
							end
						end
					end
				end
				gfm_pkg::GFM_BT_MON: begin
					mon_cnt_q <= mon_cnt_q + 1'b1;
					if (mon_cnt_q == MON_W'(MON_CYCLES - 1)) begin
						// a glitch on the pin must not leave the chip in the monitor
						if (pad_in[`GFM_PIN_BOOT])
							boot_monitor_sel <= 1'b0;
						boot_st_q <= gfm_pkg::GFM_BT_DONE;
					end
				end
				gfm_pkg::GFM_BT_DONE: begin
					boot_st_q <= gfm_pkg::GFM_BT_DONE;
				end
			endcase
		end
	end

	// pull-up only while the pin is still to be sampled, floating afterwards
	assign boot_window = boot_armed_q
		&& (boot_st_q == gfm_pkg::GFM_BT_RESET || boot_st_q == gfm_pkg::GFM_BT_WAIT);
	assign reg_ovr = ext_reg_q;
	assign dbg_ovr = !dbg_dis_q;

	// per-pin mode decode followed by the forced overrides
	always_comb begin
		logic [3:0] code;
		logic src;
		code = 4'h0;
		src = 1'b0;
		drv_d = '0;
		din_d = '0;
		for (int i = 0; i < 24; i++) begin
			code = cfg_q[i / 8][(i % 8) * 4 +: 4];
			src = ALT_PRESENT[i] ? alt_out[i] : 1'b0;
			din_d[i] = pad_in[i];
			unique case (code)
				gfm_pkg::GFM_ANALOG: din_d[i] = 1'b1;
				gfm_pkg::GFM_IN_PULL: begin
					drv_d[i].pu = latch_q[i / 8][i % 8];
					drv_d[i].pd = !latch_q[i / 8][i % 8];
				end
				gfm_pkg::GFM_OUT_PP: begin
					drv_d[i].oe = 1'b1;
					drv_d[i].out = latch_q[i / 8][i % 8];
				end
				gfm_pkg::GFM_OUT_OD: drv_d[i].oe = !latch_q[i / 8][i % 8];
				gfm_pkg::GFM_ALT_PP: begin
					drv_d[i].oe = 1'b1;
					drv_d[i].out = src;
				end
				gfm_pkg::GFM_ALT_OD: drv_d[i].oe = !src;
				// floating input and undefined codes: no drive, no pull
				default: drv_d[i] = '0;
			endcase
		end
		// overrides come last so they beat whatever the decode chose
		if (reg_ovr) begin
			drv_d[`GFM_PIN_REG] = '0;
			drv_d[`GFM_PIN_REG].oe = !reg_en_level;
			din_d[`GFM_PIN_REG] = pad_in[`GFM_PIN_REG];
		end
		if (boot_window) begin
			drv_d[`GFM_PIN_BOOT] = '0;
			drv_d[`GFM_PIN_BOOT].pu = 1'b1;
			din_d[`GFM_PIN_BOOT] = pad_in[`GFM_PIN_BOOT];
		end
		if (dbg_ovr) begin
			drv_d[`GFM_PIN_TRST] = '0;
			drv_d[`GFM_PIN_TRST].pu = 1'b1;
			drv_d[`GFM_PIN_TDI] = '0;
			drv_d[`GFM_PIN_TDI].pu = 1'b1;
			drv_d[`GFM_PIN_TDO] = '0;
			drv_d[`GFM_PIN_TDO].oe = 1'b1;
			drv_d[`GFM_PIN_TDO].out = debug_tdo;
			drv_d[`GFM_PIN_TMS] = '0;
			// the mode comes from the tool only; no register here can change it
			if (dbg_sw_mode) begin
				drv_d[`GFM_PIN_TMS].oe = swdio_oe;
				drv_d[`GFM_PIN_TMS].out = swdio_out;
			end else begin
				drv_d[`GFM_PIN_TMS].pu = 1'b1;
			end
			din_d[`GFM_PIN_TRST] = pad_in[`GFM_PIN_TRST];
			din_d[`GFM_PIN_TDI] = pad_in[`GFM_PIN_TDI];
			din_d[`GFM_PIN_TMS] = pad_in[`GFM_PIN_TMS];
		end
	end

	// pads and peripheral inputs are registered, one cycle behind the decode
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pad_out <= 24'h000000;
			pad_oe <= 24'h000000;
			pad_pu <= 24'h000000;
			pad_pd <= 24'h000000;
			din_q <= 24'hffffff;
		end else begin
			for (int i = 0; i < 24; i++) begin
				pad_out[i] <= drv_d[i].out;
				pad_oe[i] <= drv_d[i].oe;
				pad_pu[i] <= drv_d[i].pu;
				pad_pd[i] <= drv_d[i].pd;
			end
			din_q <= din_d;
		end
	end

	assign periph_in = din_q;

	// debug inputs: a released port looks like an idle, reset-held debugger
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			debug_trst_n <= 1'b0;
			debug_tdi <= 1'b1;
			debug_tms <= 1'b1;
			swdio_in <= 1'b1;
		end else begin
			debug_trst_n <= dbg_ovr ? pad_in[`GFM_PIN_TRST] : 1'b0;
			debug_tdi <= dbg_ovr ? pad_in[`GFM_PIN_TDI] : 1'b1;
			debug_tms <= (dbg_ovr && !dbg_sw_mode) ? pad_in[`GFM_PIN_TMS] : 1'b1;
			swdio_in <= (dbg_ovr && dbg_sw_mode) ? pad_in[`GFM_PIN_TMS] : 1'b1;
		end
	end

	// read path: answer one cycle after the address is taken
	assign rport = s_axi_araddr[6:5];
	assign rreg = s_axi_araddr[4:0];

	always_comb begin
		rd_d = 32'h00000000;
		rd_ok = 1'b0;
		if (s_axi_araddr[ADDR_W-1:7] == '0) begin
			if (rport == `GFM_DBG_PORT) begin
				if (rreg == `GFM_OFF_DBGCFG) begin
					rd_ok = 1'b1;
					rd_d[`GFM_DBGCFG_EXTREG] = ext_reg_q;
					rd_d[`GFM_DBGCFG_DISABLE] = dbg_dis_q;
				end else if (rreg == `GFM_OFF_DBGSTAT) begin
					rd_ok = 1'b1;
					rd_d[`GFM_STAT_FORCED] = forced_q;
					rd_d[`GFM_STAT_SWMODE] = dbg_sw_mode;
					rd_d[`GFM_STAT_BOOTSEL] = boot_flag_q;
					rd_d[`GFM_STAT_MONITOR] = boot_monitor_sel;
				end
			end else begin
				rd_ok = 1'b1;
				unique case (rreg)
					`GFM_OFF_CFG: rd_d = cfg_q[rport];
					`GFM_OFF_OUT: rd_d[7:0] = latch_q[rport];
					`GFM_OFF_IN: rd_d[7:0] = din_q[rport * 8 +: 8];
					`GFM_OFF_SET, `GFM_OFF_CLR: rd_d = 32'h00000000;
					default: rd_ok = 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `GFM_RESP_OKAY;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_d;
			rresp_q <= rd_ok ? `GFM_RESP_OKAY : `GFM_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign s_axi_awready = aw_free_q;
	assign s_axi_wready = w_free_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule // gfm_gpio

//--- verification/gfm_gpio_assertions.sv
// gfm_gpio_assertions.sv: port-level checker for gfm_gpio
// assumes one clock mclk and the synchronous block reset resetn
`timescale 1ns/100ps
module gfm_gpio_chk (
	// clock and resets
	input wire logic mclk,
	input wire logic resetn,
	input wire logic rst_por_lv,
	input wire logic rst_always_on_por,
	input wire logic rst_pin,
	input wire logic rst_wdog,
	input wire logic rst_sys_req,
	// bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// pads and debug
	input wire logic [23:0] pad_in,
	input wire logic [23:0] pad_out,
	input wire logic [23:0] pad_oe,
	input wire logic [23:0] pad_pu,
	input wire logic [23:0] pad_pd,
	input wire logic [23:0] periph_in,
	input wire logic reg_en_level,
	input wire logic dbg_sw_mode,
	input wire logic debug_tdo
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	logic rst_any;
	logic [7:0] pb_in;
	assign rst_any = rst_por_lv | rst_always_on_por | rst_pin | rst_wdog | rst_sys_req;
	assign pb_in = pad_in[15:8];
	// pads lag the config reset by one edge, hence three cycles of reset
	property p_reg_pin;
		rst_any [*3] |-> pad_oe[7] == !$past(reg_en_level) && !pad_out[7];
	endproperty
	a_reg_pin: assert property (p_reg_pin) else $error("regulator pin not forced");
	property p_dbg_pin;
		rst_any [*3] |-> pad_pu[16] && pad_pu[19] && pad_oe[18]
			&& pad_out[18] == $past(debug_tdo) && (pad_pu[20] || $past(dbg_sw_mode));
	endproperty
	a_dbg_pin: assert property (p_dbg_pin) else $error("debug pins not forced");
	property p_boot_pu;
		(rst_pin || rst_always_on_por) [*3] |-> pad_pu[5] && !pad_oe[5];
	endproperty
	a_boot_pu: assert property (p_boot_pu) else $error("boot pin not pulled up");
	property p_cfg_float;
		rst_any [*3] |-> pad_oe[15:8] == 8'h00 && pad_pu[15:8] == 8'h00 && pad_pd[15:8] == 8'h00;
	endproperty
	a_cfg_float: assert property (p_cfg_float) else $error("port b not floating");
	property p_periph;
		rst_any [*3] |-> periph_in[15:8] == $past(pb_in);
	endproperty
	a_periph: assert property (p_periph) else $error("peripheral input wrong");
	property p_wans;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wans: assert property (p_wans) else $error("write response missing");
	property p_rans;
		s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
	endproperty
	a_rans: assert property (p_rans) else $error("read response missing");
	property p_wblk;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wblk: assert property (p_wblk) else $error("write taken during response");
	property p_rblk;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rblk: assert property (p_rblk) else $error("read taken during response");
	c_rst: cover property (rst_any [*3]);
	c_wr: cover property (s_axi_bvalid);
	c_sw: cover property (dbg_sw_mode && pad_oe[20]);
endmodule // gfm_gpio_chk

bind gfm_gpio gfm_gpio_chk gfm_gpio_chk_i (.mclk, .resetn, .rst_por_lv, .rst_always_on_por,
	.rst_pin, .rst_wdog, .rst_sys_req, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pad_in,
	.pad_out, .pad_oe, .pad_pu, .pad_pd, .periph_in, .reg_en_level, .dbg_sw_mode, .debug_tdo);

//--- verification/gfm_pad_model.sv
// gfm_pad_model.sv: pad wires with external drivers and pulls
// assumes pad controls registered to mclk; nobody drives two ways at once
`timescale 1ns/100ps
module gfm_pad_model (
	// clock
	input wire logic mclk,
	// pad controls
	input wire logic [23:0] pad_out,
	input wire logic [23:0] pad_oe,
	input wire logic [23:0] pad_pu,
	input wire logic [23:0] pad_pd,
	// external drivers
	input wire logic [23:0] ext_en,
	input wire logic [23:0] ext_val,
	// resolved level
	output logic [23:0] pad_in
);
	logic tog_q = 1'b0;
	always @(posedge mclk) begin
		tog_q <= !tog_q;
	end
	// a floating pad changes every cycle so a missing drive cannot pass
	always_comb begin
		for (int i = 0; i < 24; i++) begin
			if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (ext_en[i])
				pad_in[i] = ext_val[i];
			else if (pad_pu[i] || pad_pd[i])
				pad_in[i] = pad_pu[i];
			else
				pad_in[i] = tog_q;
		end
	end
endmodule // gfm_pad_model

//--- verification/gfm_gpio_test.sv
// gfm_gpio_test.sv: register-level tests of gfm_gpio
// assumes gfm_cfg.svh on the include path
`timescale 1ns/100ps
`include "gfm_cfg.svh"
module gfm_gpio_test;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] rst_src = 5'h00;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [23:0] pad_in, pad_out, pad_oe, pad_pu, pad_pd, periph_in;
	logic [23:0] alt_out = 24'h0, ext_en = 24'h0, ext_val = 24'h0;
	logic reg_en_level = 0, dbg_pwrup_req = 0, dbg_sw_mode = 0, debug_tdo = 1;
	logic swdio_out = 0, swdio_oe = 0;
	logic osc_tick = 1'b0;
	logic debug_trst_n, debug_tdi, debug_tms, swdio_in, boot_monitor_sel;
	logic [31:0] rv;
	logic [11:0] m;
	int miscompares = 0, comparisons = 0, cyc = 0;
	// code, latch, alt, ext drive low, oe, out, pu, pd, readback
	localparam logic [11:0] mode_tbl [11] = '{12'h021, 12'h4a0, 12'h802, 12'h885, 12'h199,
		12'h110, 12'h5a0, 12'h510, 12'h959, 12'hd60, 12'hd90};

	always #20 mclk = !mclk;
	// one oscillator edge every second cycle
	always @(posedge mclk) osc_tick <= !osc_tick;

	// pin 9 has no peripheral; short monitor delay
	gfm_gpio #(.ALT_PRESENT(24'hfffdff), .MON_CYCLES(20)) gfm_gpio_i (.*,
		.rst_por_lv(rst_src[0]), .rst_always_on_por(rst_src[1]), .rst_pin(rst_src[2]),
		.rst_wdog(rst_src[3]), .rst_sys_req(rst_src[4]));
	gfm_pad_model gfm_pad_model_i (.*);

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// readies are sampled at the falling edge, stable up to the taking edge
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		tb = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!tb) begin
			@(negedge mclk);
			ta = s_axi_awvalid && s_axi_awready === 1'b1;
			tw = s_axi_wvalid && s_axi_wready === 1'b1;
			tb = s_axi_bvalid === 1'b1;
			r = s_axi_bresp;
			@(posedge mclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
		end
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		tr = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!tr) begin
			@(negedge mclk);
			ta = s_axi_arvalid && s_axi_arready === 1'b1;
			tr = s_axi_rvalid === 1'b1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge mclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
		end
	endtask
	task settle;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
	endtask
	// compares oe, out while driven, pu, pd of one pad
	task pins(input int i, input logic [3:0] e);
		chk({28'h0, pad_oe[i], pad_oe[i] & pad_out[i], pad_pu[i], pad_pd[i]}, {28'h0, e});
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			finish_test;
		end
	end

	initial begin
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		settle;
		for (int p = 0; p < 3; p++) begin
			rd(8'(p * 32), rv, rs);
			chk(rv, `GFM_CFG_RESET);
		end
		rd(8'h60, rv, rs);
		chk(rv, 32'h1);
		rd(8'h64, rv, rs);
		chk(rv[1], 1'b0);
		settle;
		pins(7, 4'h8);
		pins(16, 4'h2);
		pins(19, 4'h2);
		pins(20, 4'h2);
		pins(18, 4'hc);
		chk(pad_pu[5], 1'b1);
		chk(debug_trst_n, 1'b1);
		@(posedge mclk);
		reg_en_level <= 1'b1;
		debug_tdo <= 1'b0;
		ext_en[20:19] <= 2'h3;
		settle;
		pins(7, 4'h0);
		pins(18, 4'h8);
		chk(debug_tdi, 1'b0);
		chk(debug_tms, 1'b0);
		for (int k = 0; k < 11; k++) begin
			m = mode_tbl[k];
			wr(8'h24, {31'h0, m[7]}, rs);
			alt_out[8] <= m[6];
			ext_en[8] <= m[5];
			wr(8'h20, {28'h4444444, m[11:8]}, rs);
			settle;
			pins(8, m[4:1]);
			chk(periph_in[8], m[0]);
			rd(8'h30, rv, rs);
			chk(rv[0], m[0]);
		end
		wr(8'h20, 32'h44444494, rs);
		alt_out[9] <= 1'b1;
		settle;
		pins(9, 4'h8);
		wr(8'h24, 32'h5a, rs);
		wr(8'h28, 32'h81, rs);
		rd(8'h24, rv, rs);
		chk(rv, 32'hdb);
		wr(8'h2c, 32'h18, rs);
		rd(8'h24, rv, rs);
		chk(rv, 32'hc3);
		rd(8'h28, rv, rs);
		chk(rv, 32'h0);
		wr(8'h00, 32'h14444444, rs);
		wr(8'h04, 32'h80, rs);
		settle;
		pins(7, 4'h0);
		wr(8'h60, 32'h0, rs);
		settle;
		pins(7, 4'hc);
		@(posedge mclk);
		dbg_pwrup_req <= 1'b1;
		wr(8'h60, 32'h2, rs);
		rd(8'h60, rv, rs);
		chk(rv, 32'h0);
		dbg_pwrup_req <= 1'b0;
		for (int s = 0; s < 5; s++) begin
			wr(8'h60, 32'h2, rs);
			wr(8'h20, 32'h0, rs);
			settle;
			pins(16, 4'h0);
			pins(18, 4'h0);
			@(posedge mclk);
			rst_src[s] <= 1'b1;
			dbg_pwrup_req <= 1'b1;
			repeat (4) @(posedge mclk);
			rst_src[s] <= 1'b0;
			settle;
			rd(8'h20, rv, rs);
			chk(rv, `GFM_CFG_RESET);
			rd(8'h60, rv, rs);
			chk(rv, 32'h1);
			rd(8'h64, rv, rs);
			chk(rv[0], 1'b1);
			pins(16, 4'h2);
			dbg_pwrup_req <= 1'b0;
		end
		dbg_sw_mode <= 1'b1;
		swdio_oe <= 1'b1;
		swdio_out <= 1'b1;
		settle;
		pins(20, 4'hc);
		rd(8'h64, rv, rs);
		chk(rv[1], 1'b1);
		wr(8'h64, 32'h0, rs);
		chk(rs, `GFM_RESP_SLVERR);
		swdio_oe <= 1'b0;
		ext_en[20] <= 1'b1;
		settle;
		pins(20, 4'h0);
		chk(swdio_in, 1'b0);
		chk(debug_tms, 1'b1);
		rd(8'h7c, rv, rs);
		chk(rs, `GFM_RESP_SLVERR);
		chk(rv, 32'h0);
		// boot pin low through a pin reset; the second pass lets go before the re-sample
		ext_en[5] <= 1'b1;
		for (int b = 0; b < 2; b++) begin
			@(posedge mclk);
			ext_val[5] <= 1'b0;
			rst_src[2] <= 1'b1;
			repeat (4) @(posedge mclk);
			rst_src[2] <= 1'b0;
			settle;
			chk(pad_pu[5], 1'b1);
			repeat (1030) @(negedge mclk);
			chk(pad_pu[5], 1'b0);
			rd(8'h64, rv, rs);
			chk(rv[3:2], 2'h2);
			ext_val[5] <= b[0];
			repeat (20) @(negedge mclk);
			chk(boot_monitor_sel, !b[0]);
		end
		// a watchdog reset must not re-arm the pull-up nor touch the flag
		@(posedge mclk);
		rst_src[3] <= 1'b1;
		repeat (4) @(posedge mclk);
		rst_src[3] <= 1'b0;
		settle;
		chk(pad_pu[5], 1'b0);
		rd(8'h64, rv, rs);
		chk(rv[2], 1'b0);
		finish_test;
	end
endmodule // gfm_gpio_test
